// ---- pcs_pkg.sv ----
package pcs_pkg;

    // ********************************************************
    // Widths
    // ********************************************************
    localparam int PC_W        = 13;
    localparam int PCL_W       = 8;
    localparam int PCH_W       = 5;
    localparam int JUMP_W      = 11;
    localparam int STACK_DEPTH = 8;
    localparam int DATA_W      = 8;
    localparam int IND_ADDR_W  = 9;
    localparam int PAGE_BIT    = 3;

    // ********************************************************
    // Register map (word index; byte address is four times it)
    // ********************************************************
    localparam logic [3:0] REG_PCL       = 4'h0;
    localparam logic [3:0] REG_LATCH     = 4'h1;
    localparam logic [3:0] REG_PTR       = 4'h2;
    localparam logic [3:0] REG_BANK      = 4'h3;
    localparam logic [3:0] REG_IND_DATA  = 4'h4;
    localparam logic [3:0] REG_PC_FULL   = 4'h5;
    localparam logic [3:0] REG_SEQ_CMD   = 4'h6;
    localparam logic [3:0] REG_IND_ADDR  = 4'h7;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
    localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
    localparam logic [DATA_W-1:0] PTR_RST   = 8'h00;
    localparam logic [DATA_W-1:0] SELF_READ = 8'h00;
    localparam logic [DATA_W-1:0] SELF_ADDR = 8'h00;
    localparam logic [31:0]       UNMAPPED  = 32'h0000_0000;

    // ********************************************************
    // Sequencer commands
    // ********************************************************
    typedef enum logic [2:0] {
        PCS_CMD_NONE,
        PCS_CMD_STEP,
        PCS_CMD_JUMP,
        PCS_CMD_CALL,
        PCS_CMD_INTR,
        PCS_CMD_RETURN,
        PCS_CMD_RETURN_LIT,
        PCS_CMD_RETURN_INT
    } pcs_cmd_t;

    typedef struct packed {
        pcs_cmd_t            cmd;
        logic [JUMP_W-1:0]   target;
    } pcs_seq_req_t;

    localparam logic [PC_W-1:0] INTR_VECTOR = 13'h0004;

endpackage : pcs_pkg

// ---- pcs_stack.sv ----
`timescale 1ns/1ps
module pcs_stack
    import pcs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Operations
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    ptr_q;

    // Pointer wraps silently: no overflow or underflow is reported
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ptr_q <= '0;
        end else if (push) begin
            ptr_q <= ptr_q + PW'(1);
        end else if (pop) begin
            ptr_q <= ptr_q - PW'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (push) begin
            mem_q[ptr_q] <= push_data;
        end
    end

    assign top_data = mem_q[ptr_q - PW'(1)];

endmodule : pcs_stack

// ---- pcs_sequencer.sv ----
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - 13-bit counter; only low byte writable, full value readable
// - Low-byte write loads high bits from latch
// - Jump/call: 11 instruction bits, latch bits 4:3
// - Call or interrupt pushes full counter
// - Eight-deep, 13-bit stack, pointer hidden
// - Returns pop the stack into counter
// - Push and pop leave latch alone
// - Stack wraps; ninth push overwrites first
// - Indirect port redirects to pointed register
// - Indirect read of itself returns zero
// - Indirect write to itself changes nothing
// - Address is bank bit over pointer
module pcs_sequencer
    import pcs_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Avalon-MM slave
    input  wire logic [5:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Instruction sequencing from the executor
    input  wire pcs_seq_req_t          seq_req,
    // Program memory fetch address
    output logic      [PC_W-1:0]       fetch_addr,
    // Data memory port for indirect access
    output logic      [IND_ADDR_W-1:0] dmem_addr,
    output logic                       dmem_read,
    output logic                       dmem_write,
    output logic      [DATA_W-1:0]     dmem_wdata,
    input  wire logic [DATA_W-1:0]     dmem_rdata,
    input  wire logic                  dmem_ready
);

    // ********************************************************
    // State
    // ********************************************************
    typedef enum {
        PCS_IDLE,
        PCS_IND,
        PCS_DONE
    } pcs_bus_st_t;

    pcs_bus_st_t       st_q;
    logic [PC_W-1:0]   pc_q;
    logic [DATA_W-1:0] latch_q;
    logic [DATA_W-1:0] ptr_q;
    logic              bank_q;
    logic [31:0]       rdata_q;
    logic              ind_wr_q;
    logic [DATA_W-1:0] ind_wdata_q;

    logic [3:0]        reg_idx;
    logic              bus_req;
    logic              wr_fire;
    logic              ind_self;
    logic              pcl_wr;
    logic              do_push;
    logic              do_pop;
    logic [PC_W-1:0]   stack_top;
    logic [PC_W-1:0]   pc_plus;
    logic              wr_lo;
    logic              is_cmd_wr;
    pcs_cmd_t          bus_cmd;
    pcs_cmd_t          cmd;
    logic [JUMP_W-1:0] target;

    assign reg_idx  = avs_address[5:2];
    assign bus_req  = avs_read | avs_write;
    assign wr_lo    = avs_byteenable[0];
    assign ind_self = (ptr_q == SELF_ADDR);
    assign pc_plus  = pc_q + PC_W'(1);

    // Bus may drive the sequencer too; the executor port wins on collision
    assign is_cmd_wr = (st_q == PCS_IDLE) && avs_write && (reg_idx == REG_SEQ_CMD);
    assign bus_cmd   = pcs_cmd_t'(avs_writedata[JUMP_W+2:JUMP_W]);
    always_comb begin
        cmd    = seq_req.cmd;
        target = seq_req.target;
        if (seq_req.cmd == PCS_CMD_NONE && is_cmd_wr && avs_byteenable[1]) begin
            cmd    = bus_cmd;
            target = avs_writedata[JUMP_W-1:0];
        end
    end

    // ********************************************************
    // Avalon-MM handshake
    // ********************************************************
    // Plain registers answer in the cycle after the request; indirect
    // access waits on data memory, so no fixed latency can be promised
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= PCS_IDLE;
        end else begin
            case (st_q)
                PCS_IDLE: begin
                    if (bus_req) begin
                        // A write with the low byte disabled never touches memory
                        if (reg_idx == REG_IND_DATA && !ind_self && (avs_read || wr_lo)) begin
                            st_q <= PCS_IND;
                        end else begin
                            st_q <= PCS_DONE;
                        end
                    end
                end
                PCS_IND: begin
                    if (dmem_ready) begin
                        st_q <= PCS_DONE;
                    end
                end
                PCS_DONE: st_q <= PCS_IDLE;
                default:  st_q <= PCS_IDLE;
            endcase
        end
    end

    assign avs_waitrequest = !(st_q == PCS_DONE);
    assign avs_readdata    = rdata_q;
    // Register writes land on the request's first cycle, answered next
    assign wr_fire         = (st_q == PCS_IDLE) && avs_write;
    assign pcl_wr          = wr_fire && wr_lo && (reg_idx == REG_PCL);

    // ********************************************************
    // Read data
    // ********************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= UNMAPPED;
        end else if (st_q == PCS_IND && dmem_ready) begin
            rdata_q <= {24'h00_0000, dmem_rdata};
        end else if (st_q == PCS_IDLE && avs_read) begin
            case (reg_idx)
                REG_PCL:      rdata_q <= {24'h00_0000, pc_q[PCL_W-1:0]};
                REG_LATCH:    rdata_q <= {24'h00_0000, latch_q};
                REG_PTR:      rdata_q <= {24'h00_0000, ptr_q};
                REG_BANK:     rdata_q <= {31'h0000_0000, bank_q};
                REG_IND_DATA: rdata_q <= {24'h00_0000, SELF_READ};
                REG_PC_FULL:  rdata_q <= {19'h0_0000, pc_q};
                REG_IND_ADDR: rdata_q <= {23'h00_0000, dmem_addr};
                default:      rdata_q <= UNMAPPED;
            endcase
        end
    end

    // ********************************************************
    // Latch, pointer and bank bit
    // ********************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            latch_q <= LATCH_RST;
        end else if (wr_fire && wr_lo && reg_idx == REG_LATCH) begin
            latch_q <= avs_writedata[DATA_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ptr_q  <= PTR_RST;
            bank_q <= 1'b0;
        end else if (wr_fire && wr_lo && reg_idx == REG_PTR) begin
            ptr_q  <= avs_writedata[DATA_W-1:0];
        end else if (wr_fire && wr_lo && reg_idx == REG_BANK) begin
            bank_q <= avs_writedata[0];
        end
    end

    // ********************************************************
    // Program counter
    // ********************************************************
    assign do_push = (cmd == PCS_CMD_CALL) || (cmd == PCS_CMD_INTR);
    assign do_pop  = (cmd == PCS_CMD_RETURN) || (cmd == PCS_CMD_RETURN_LIT)
                  || (cmd == PCS_CMD_RETURN_INT);

    // A low-byte write overrides any sequencing in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q <= PC_RST;
        end else if (pcl_wr) begin
            pc_q <= {latch_q[PCH_W-1:0], avs_writedata[PCL_W-1:0]};
        end else begin
            case (cmd)
                PCS_CMD_STEP:   pc_q <= pc_plus;
                PCS_CMD_JUMP,
                PCS_CMD_CALL:   pc_q <= {latch_q[PCH_W-1:PAGE_BIT+1],
                                         latch_q[PAGE_BIT], target};
                PCS_CMD_INTR:   pc_q <= INTR_VECTOR;
                PCS_CMD_RETURN,
                PCS_CMD_RETURN_LIT,
                PCS_CMD_RETURN_INT: pc_q <= stack_top;
                default:        pc_q <= pc_q;
            endcase
        end
    end

    assign fetch_addr = pc_q;

    // Call saves the return address; interrupt saves the current one
    pcs_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_W)
    ) u_stack (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .push      (do_push && !pcl_wr),
        .pop       (do_pop && !pcl_wr),
        .push_data ((cmd == PCS_CMD_CALL) ? pc_plus : pc_q),
        .top_data  (stack_top)
    );

    // ********************************************************
    // Indirect data port
    // ********************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ind_wr_q    <= 1'b0;
            ind_wdata_q <= 8'h00;
        end else if (st_q == PCS_IDLE && bus_req) begin
            ind_wr_q    <= avs_write && wr_lo;
            ind_wdata_q <= avs_writedata[DATA_W-1:0];
        end
    end

    assign dmem_addr  = {bank_q, ptr_q};
    assign dmem_read  = (st_q == PCS_IND) && !ind_wr_q;
    // A self-addressed write never enters PCS_IND, so no store occurs
    assign dmem_write = (st_q == PCS_IND) && ind_wr_q;
    assign dmem_wdata = ind_wdata_q;

endmodule : pcs_sequencer

// ---- pcs_chk.sv ----
`timescale 1ns/1ps
module pcs_chk
    import pcs_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  rst,
    // Register bus
    input wire logic [5:0]            avs_address,
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic [31:0]           avs_writedata,
    input wire logic [3:0]            avs_byteenable,
    input wire logic [31:0]           avs_readdata,
    input wire logic                  avs_waitrequest,
    // Sequencing and data port
    input wire pcs_seq_req_t          seq_req,
    input wire logic [PC_W-1:0]       fetch_addr,
    input wire logic [IND_ADDR_W-1:0] dmem_addr,
    input wire logic                  dmem_read,
    input wire logic                  dmem_write,
    input wire logic [DATA_W-1:0]     dmem_rdata,
    input wire logic                  dmem_ready
);
    logic [3:0]  idx;
    logic [7:0]  wd_lo;
    logic [10:0] tgt;
    logic        slf;
    assign idx   = avs_address[5:2];
    assign wd_lo = avs_writedata[7:0];
    assign tgt   = seq_req.target;
    // Self-addressing depends on the pointer alone; the bank bit is unused
    assign slf   = (dmem_addr[7:0] == 8'h00);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_call;
        seq_req.cmd == PCS_CMD_CALL && !avs_write;
    endsequence
    sequence s_ret;
        seq_req.cmd == PCS_CMD_RETURN && !avs_write;
    endsequence
    // ********************************************************
    // Sequencing
    // ********************************************************
    a_step_incr: assert property (seq_req.cmd == PCS_CMD_STEP && !avs_write
        |=> fetch_addr == $past(fetch_addr) + 13'h0001) else $error("step did not increment");
    a_jump_low: assert property (seq_req.cmd == PCS_CMD_JUMP && !avs_write
        |=> fetch_addr[10:0] == $past(tgt)) else $error("jump target wrong");
    a_intr_vec: assert property (seq_req.cmd == PCS_CMD_INTR && !avs_write
        |=> fetch_addr == INTR_VECTOR) else $error("interrupt vector wrong");
    a_call_ret: assert property (s_call ##1 s_ret
        |=> fetch_addr == $past(fetch_addr, 2) + 13'h0001) else $error("return address wrong");
    a_pcl_write: assert property (avs_write && idx == REG_PCL && avs_byteenable[0]
        && avs_waitrequest |=> fetch_addr[7:0] == $past(wd_lo)) else $error("low byte not loaded");
    // ********************************************************
    // Indirect port
    // ********************************************************
    a_self_rd: assert property (avs_read && idx == REG_IND_DATA && slf && avs_waitrequest
        |=> !avs_waitrequest && avs_readdata == 32'h0000_0000) else $error("self read not zero");
    a_self_wr: assert property (avs_write && idx == REG_IND_DATA && slf && avs_waitrequest
        |=> !avs_waitrequest && !dmem_write) else $error("self write reached memory");
    a_ind_start: assert property (avs_read && idx == REG_IND_DATA && !slf && avs_waitrequest
        && !dmem_read |=> dmem_read) else $error("indirect read not issued");
    a_ind_done: assert property (dmem_read && dmem_ready
        |=> !avs_waitrequest && avs_readdata[7:0] == $past(dmem_rdata)) else $error("bad data");
endmodule : pcs_chk
bind pcs_sequencer pcs_chk u_chk (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .seq_req(seq_req), .fetch_addr(fetch_addr),
    .dmem_addr(dmem_addr), .dmem_read(dmem_read), .dmem_write(dmem_write),
    .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready));

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import pcs_pkg::*;
    logic         clk_sys, rst, avs_read, avs_write, avs_waitrequest;
    logic         dmem_read, dmem_write, dmem_ready;
    logic [5:0]   avs_address;
    logic [3:0]   avs_byteenable;
    logic [31:0]  avs_writedata, avs_readdata, rd, v;
    pcs_seq_req_t seq_req;
    logic [12:0]  fetch_addr, pc_m;
    logic [8:0]   dmem_addr;
    logic [7:0]   dmem_wdata, dmem_rdata, latch_m, p;
    logic [7:0]   mem [512];
    logic [12:0]  stk [8];
    logic [3:0]   ri [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hA};
    int           err_count, n_compared, seed, sp;
    pcs_sequencer dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .seq_req(seq_req), .fetch_addr(fetch_addr),
        .dmem_addr(dmem_addr), .dmem_read(dmem_read), .dmem_write(dmem_write),
        .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready));
    always #2.5 clk_sys = ~clk_sys;
    // Data memory answers after a random stall; idle data is inverted so it never looks valid
    always @(posedge clk_sys) begin
        dmem_ready <= (dmem_read || dmem_write) && !dmem_ready && ($random(seed) % 2 == 0);
        dmem_rdata <= dmem_read ? mem[dmem_addr] : ~mem[dmem_addr];
        if (dmem_write && dmem_ready)
            mem[dmem_addr] <= dmem_wdata;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
        int   n;
        logic ok;
        @(posedge clk_sys);
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= wd;
        n  = 0;
        ok = 1'b0;
        while (!ok && n < 100) begin
            @(posedge clk_sys);
            ok = !avs_waitrequest;
            rd = avs_readdata;
            n++;
        end
        if (ok) begin
            avs_write <= 1'b0;
            avs_read  <= 1'b0;
        end else begin
            err_count++;
            tally_and_finish;
        end
    endtask : bus
    function void push(input logic [12:0] a);
        stk[sp] = a;
        sp = (sp + 1) % 8;
    endfunction : push
    task cmd(input pcs_cmd_t c, input logic [10:0] t);
        @(posedge clk_sys);
        seq_req <= '{c, t};
        @(posedge clk_sys);
        seq_req <= '{PCS_CMD_NONE, 11'h000};
        case (c)
            PCS_CMD_NONE: ;
            PCS_CMD_STEP: pc_m = pc_m + 13'h0001;
            PCS_CMD_JUMP: pc_m = {latch_m[4:3], t};
            PCS_CMD_CALL: begin
                push(pc_m + 13'h0001);
                pc_m = {latch_m[4:3], t};
            end
            PCS_CMD_INTR: begin
                push(pc_m);
                pc_m = INTR_VECTOR;
            end
            default: begin
                sp = (sp + 7) % 8;
                pc_m = stk[sp];
            end
        endcase
        #1;
        chk("fetch_addr", fetch_addr, pc_m);
    endtask : cmd
    initial begin
        seed = 35181;
        {err_count, n_compared, sp} = '0;
        {clk_sys, avs_read, avs_write, dmem_ready} = '0;
        {pc_m, latch_m, avs_address, avs_writedata, dmem_rdata} = '0;
        rst = 1'b1;
        avs_byteenable = 4'hF;
        seq_req = '{PCS_CMD_NONE, 11'h000};
        for (int i = 0; i < 512; i++)
            mem[i] = 8'($random(seed));
        for (int i = 0; i < 8; i++)
            stk[i] = 13'h0000;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ri[i]) begin
            bus(1'b0, ri[i], 32'h0000_0000);
            chk("reset_value", rd, 32'h0000_0000);
        end
        // ********************************************************
        // Full counter load through the latch
        // ********************************************************
        latch_m = 8'($random(seed));
        bus(1'b1, REG_LATCH, {24'h0000_00, latch_m});
        v = $random(seed);
        bus(1'b1, REG_PCL, v);
        pc_m = {latch_m[4:0], v[7:0]};
        chk("pcl_write", fetch_addr, pc_m);
        bus(1'b0, REG_PCL, 32'h0000_0000);
        chk("pcl_read", rd, {24'h0000_00, pc_m[7:0]});
        bus(1'b0, REG_PC_FULL, 32'h0000_0000);
        chk("pc_full", rd, {19'h0_0000, pc_m});
        // Computed branch past a low-byte wrap: software bumps the latch first
        latch_m = 8'h0A;
        bus(1'b1, REG_LATCH, {24'h00_0000, latch_m});
        bus(1'b1, REG_PCL, 32'h0000_00FF);
        pc_m = 13'h0AFF;
        cmd(PCS_CMD_STEP, 11'h000);
        latch_m = latch_m + 8'h01;
        bus(1'b1, REG_LATCH, {24'h00_0000, latch_m});
        bus(1'b1, REG_PCL, 32'h0000_0005);
        pc_m = {latch_m[4:0], 8'h05};
        chk("table_branch", fetch_addr, pc_m);
        // Jump issued through the bus command register
        bus(1'b1, REG_SEQ_CMD, {18'h0_0000, PCS_CMD_JUMP, 11'h2A5});
        pc_m = {latch_m[4:3], 11'h2A5};
        chk("bus_jump", fetch_addr, pc_m);
        // Low-byte write with its byte lane disabled must leave the counter alone
        avs_byteenable <= 4'hE;
        bus(1'b1, REG_PCL, 32'h0000_0033);
        avs_byteenable <= 4'hF;
        chk("pcl_masked", fetch_addr, pc_m);
        for (int c = 0; c < 8; c++)
            cmd(pcs_cmd_t'(c), 11'($random(seed)));
        repeat (60) begin
            if ($random(seed) % 4 == 0) begin
                latch_m = 8'($random(seed));
                bus(1'b1, REG_LATCH, {24'h0000_00, latch_m});
            end
            cmd(pcs_cmd_t'($random(seed) & 7), 11'($random(seed)));
        end
        // Nine calls wrap the stack; nine returns of all kinds walk it back
        for (int i = 0; i < 18; i++)
            cmd(i < 9 ? PCS_CMD_CALL : pcs_cmd_t'(5 + i % 3), 11'($random(seed)));
        bus(1'b0, REG_LATCH, 32'h0000_0000);
        chk("latch_kept", rd, {24'h0000_00, latch_m});
        // Reset in mid-run: counter and latch must clear again
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        {pc_m, latch_m, sp} = '0;
        #1;
        chk("rst_pc", fetch_addr, pc_m);
        bus(1'b0, REG_LATCH, 32'h0000_0000);
        chk("rst_latch", rd, 32'h0000_0000);
        // ********************************************************
        // Indirect access
        // ********************************************************
        p = 8'($random(seed)) | 8'h01;
        bus(1'b1, REG_BANK, 32'h0000_0001);
        bus(1'b1, REG_PTR, {24'h0000_00, p});
        chk("dmem_addr", dmem_addr, {1'b1, p});
        bus(1'b0, REG_IND_ADDR, 32'h0000_0000);
        chk("ind_addr", rd, {23'h00_0000, 1'b1, p});
        v = $random(seed);
        bus(1'b1, REG_IND_DATA, v);
        chk("ind_write", mem[{1'b1, p}], v[7:0]);
        bus(1'b0, REG_IND_DATA, 32'h0000_0000);
        chk("ind_read", rd, {24'h0000_00, v[7:0]});
        bus(1'b1, REG_BANK, 32'h0000_0000);
        bus(1'b1, REG_PTR, 32'h0000_0000);
        p = mem[0];
        bus(1'b1, REG_IND_DATA, 32'h0000_005A);
        chk("self_write", mem[0], p);
        bus(1'b0, REG_IND_DATA, 32'h0000_0000);
        chk("self_read", rd, 32'h0000_0000);
        tally_and_finish;
    end
endmodule : testbench
